// [rtl/gyro_spi_message_slave.sv]
// serial mode 0 slave exchanging six-byte command and status frames
`timescale 1ns/1ps
`default_nettype none
`include "gyro_spi_cfg.svh"

module gyro_spi_message_slave
    import gyro_spi_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // serial link pins
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    // sensor side
    input wire sample_t sample,
    input wire logic health_fail,
    output cmd_cfg_t cfg,
    output logic bit_ok,
    output logic frame_done
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] inv_sum(input logic [39:0] b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 5; i++)
        begin
            s = 8'(s + b[8*i +: 8]);
        end
        return ~s;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] sclk_s_q, ss_s_q, mosi_s_q;
    logic sclk_d1_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_s_q <= 2'h0;
            ss_s_q <= 2'h3;
            mosi_s_q <= 2'h0;
            sclk_d1_q <= 1'b0;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[0], sclk};
            ss_s_q <= {ss_s_q[0], ss_n};
            mosi_s_q <= {mosi_s_q[0], mosi};
            sclk_d1_q <= sclk_s_q[1];
        end
    end
    logic sclk_r, ss_r, mosi_r, rise, fall;
    assign sclk_r = sclk_s_q[1];
    assign ss_r = ss_s_q[1];
    assign mosi_r = mosi_s_q[1];
    assign rise = sclk_r & ~sclk_d1_q & ~ss_r;
    assign fall = ~sclk_r & sclk_d1_q & ~ss_r;

    // ****************************************
    // frame shifting and command decode
    // ****************************************
    logic ss_d1_q, ss_d1_d;
    logic [47:0] rx_q, rx_d, tx_q, tx_d;
    logic [5:0] cnt_q, cnt_d;
    cmd_cfg_t cfg_q, cfg_d;
    logic bad_q, bad_d, done_q, done_d;
    logic [39:0] sts;
    logic [7:0] sts_b1;

    // status byte: fail, type, previous invalid, self-test, 001
    assign sts_b1 = {health_fail | cfg_q.self_test,
        `STS_MSG_TYPE, bad_q, cfg_q.self_test, `STS_LOW_BITS};
    // rate carries the self-test offset from the sensor; temp is raw code
    assign sts = {sts_b1, sample.rate, sample.temp};

    always_comb
    begin
        ss_d1_d = ss_r;
        rx_d = rx_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        cfg_d = cfg_q;
        bad_d = bad_q;
        done_d = 1'b0;
        if (ss_d1_q && !ss_r)
        begin
            // frame start: load status so bit 47 is out before first rise
            tx_d = {sts, inv_sum(sts)};
            cnt_d = 6'h00;
        end
        else if (rise)
        begin
            rx_d = {rx_q[46:0], mosi_r};
            cnt_d = 6'(cnt_q + 6'h01);
        end
        else if (fall)
        begin
            tx_d = {tx_q[46:0], 1'b0};
        end
        if (!ss_d1_q && ss_r && cnt_q == 6'(`MSG_BITS))
        begin
            done_d = 1'b1;
            // bytes one to five all count toward the checksum
            if (rx_q[7:0] == inv_sum(rx_q[47:8]))
            begin
                bad_d = 1'b0;
                cfg_d.self_test = rx_q[40+`CMD_SELF_TEST_BIT];
                cfg_d.range_sel = rx_q[40+`CMD_RANGE_SRC_BIT];
                cfg_d.range_code = rx_q[44:43];
            end
            else
            begin
                bad_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            ss_d1_q <= 1'b1;
            rx_q <= 48'h0000_0000_0000;
            tx_q <= 48'h0000_0000_0000;
            cnt_q <= 6'h00;
            cfg_q <= cmd_cfg_t'(`CFG_RESET);
            bad_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            ss_d1_q <= ss_d1_d;
            rx_q <= rx_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            cfg_q <= cfg_d;
            bad_q <= bad_d;
            done_q <= done_d;
        end
    end

    assign miso_o = tx_q[47];
    assign miso_oe = ~ss_r;
    assign cfg = cfg_q;
    assign bit_ok = ~cfg_q.self_test;
    assign frame_done = done_q;

    // ****************************************
    // checks
    // ****************************************
    sequence frame_begin;
        ss_d1_q && !ss_r;
    endsequence
    sequence select_rise;
        !ss_d1_q && ss_r;
    endsequence
    sequence frame_end;
        select_rise ##0 (cnt_q == 6'(`MSG_BITS));
    endsequence
    a_tristate_idle: assert property (@(posedge mclk) disable iff (!rstn)
        ss_r |-> !miso_oe) else $error("data out driven while deselected");
    a_selftest_fail_flag: assert property (@(posedge mclk) disable iff (!rstn)
        cfg_q.self_test |-> sts_b1[7] && sts_b1[3]) else $error("self-test flags wrong");
    a_bitout_follows: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(cfg_q.self_test) |-> !bit_ok) else $error("built-in-test not false");
    a_bad_keeps_cfg: assert property (@(posedge mclk) disable iff (!rstn)
        frame_end ##0 (rx_q[7:0] != inv_sum(rx_q[47:8])) |=> bad_q && $stable(cfg_q))
        else $error("corrupt command changed config");
    a_good_loads_cfg: assert property (@(posedge mclk) disable iff (!rstn)
        frame_end ##0 (rx_q[7:0] == inv_sum(rx_q[47:8])) |=> !bad_q
        && cfg_q.self_test == $past(rx_q[46])) else $error("valid command not applied");
    a_msg_type_low: assert property (@(posedge mclk) disable iff (!rstn)
        sts_b1[6:5] == 2'h0 && sts_b1[2:0] == 3'h1) else $error("status constant bits wrong");
    a_frame_length: assert property (@(posedge mclk) disable iff (!rstn)
        frame_done |-> $past(cnt_q) == 6'(`MSG_BITS)) else $error("frame length not 48");
    a_health_flag: assert property (@(posedge mclk) disable iff (!rstn)
        health_fail |-> sts_b1[7]) else $error("health fail not reported");
    // status must be whole before the first rise, since mode 0 samples bit 47 there
    a_status_loaded: assert property (@(posedge mclk) disable iff (!rstn)
        frame_begin |=> tx_q == {$past(sts), inv_sum($past(sts))})
        else $error("status frame not loaded at select");
    a_rise_samples: assert property (@(posedge mclk) disable iff (!rstn)
        rise |=> rx_q[0] == $past(mosi_r)) else $error("data in not taken on clock rise");
    a_done_one_cycle: assert property (@(posedge mclk) disable iff (!rstn)
        frame_done |=> !frame_done) else $error("frame done longer than one cycle");
    a_short_ignored: assert property (@(posedge mclk) disable iff (!rstn)
        select_rise ##0 (cnt_q != 6'(`MSG_BITS)) |=> !frame_done && $stable(cfg_q)
        && $stable(bad_q)) else $error("short frame changed state");
endmodule
`default_nettype wire

// [rtl/gyro_spi_cfg.svh]
// frame length, field and reset constants for the gyro serial message slave
`ifndef GYRO_SPI_CFG_SVH
`define GYRO_SPI_CFG_SVH
`define MSG_BYTES 6
`define MSG_BITS 48
`define CMD_FACTORY_BIT 7
`define CMD_SELF_TEST_BIT 6
`define CMD_RANGE_SRC_BIT 5
`define STS_MSG_TYPE 2'h0
`define STS_LOW_BITS 3'h1
`define TEMP_ZERO_C 16'h0200
`define CFG_RESET 4'h0
`endif

// [rtl/gyro_spi_pkg.sv]
// types shared by the gyro serial message slave
package gyro_spi_pkg;
    typedef struct packed {
        logic self_test;
        logic range_sel;
        logic [1:0] range_code;
    } cmd_cfg_t;
    typedef struct packed {
        logic [15:0] rate;
        logic [15:0] temp;
    } sample_t;
endpackage

// [tb/host_master.sv]
// serial bus master model for the gyro message slave
`timescale 1ns/1ps
`default_nettype none
module host_master (
    // clock
    input wire logic mclk,
    // serial link
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    initial
    begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // 4 mclk half period gives a 200 ns link clock
    task automatic xfer(input logic [47:0] tx, input int n, output logic [47:0] rx);
        rx = '0;
        @(negedge mclk);
        ss_n = 1'b0;
        repeat (8) @(negedge mclk);
        for (int i = 0; i < n; i++)
        begin
            mosi = tx[47-i];
            repeat (4) @(negedge mclk);
            sclk = 1'b1;
            rx = {rx[46:0], miso};
            repeat (4) @(negedge mclk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge mclk);
        ss_n = 1'b1;
        // a released line must not keep its last value
        mosi = ~mosi;
        repeat (8) @(negedge mclk);
        // pad each 48-bit message to 100 us, the fastest poll rate allowed
        repeat (3596) @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking testbench for the gyro serial message slave
`timescale 1ns/1ps
`default_nettype none
`include "gyro_spi_cfg.svh"
module tb_top;
    import gyro_spi_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic health_fail = 1'b0;
    sample_t sample = {16'hf4c0, 16'h0200};
    wire logic sclk, ss_n, mosi, miso, miso_o, miso_oe, bit_ok, frame_done;
    wire cmd_cfg_t cfg;
    int fails = 0, n_compared = 0, n_done = 0, cycles = 0;
    logic [47:0] rx;
    // undriven miso shows the inverse so a stale bit never passes
    assign miso = miso_oe ? miso_o : ~miso_o;
    always #12.5 mclk = ~mclk;
    gyro_spi_message_slave dut_u (.mclk(mclk), .rstn(rstn), .sclk(sclk), .ss_n(ss_n),
        .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .sample(sample),
        .health_fail(health_fail), .cfg(cfg), .bit_ok(bit_ok), .frame_done(frame_done));
    host_master host_u (.mclk(mclk), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));
    always @(posedge mclk)
    begin
        cycles++;
        if (frame_done === 1'b1)
            n_done++;
        if (cycles == 40000)
        begin
            fails++;
            wrap_up();
        end
    end
    function automatic logic [47:0] with_sum(input logic [39:0] b);
        logic [7:0] s;
        s = '0;
        for (int i = 0; i < 5; i++)
            s = s + b[8*i +: 8];
        return {b, ~s};
    endfunction
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (!ok)
        begin
            fails++;
            $display("CHECK FAILED %0t %s", $time, what);
        end
    endtask
    task automatic wrap_up();
        if (fails == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic run(input logic [47:0] tx, input int n, input logic st, input logic bad);
        int d;
        d = n_done;
        host_u.xfer(tx, n, rx);
        if (n == 48)
            check(rx === with_sum({health_fail | st, `STS_MSG_TYPE, bad, st,
                `STS_LOW_BITS, sample}), "status frame");
        check(n_done == d + (n == 48), "frame done count");
        check(miso_oe === 1'b0, "miso released");
    endtask
    // ********************************
    // scenarios
    // ********************************
    initial
    begin
        repeat (10) @(negedge mclk);
        check(cfg === 4'h0 && bit_ok === 1'b1 && miso_oe === 1'b0, "reset");
        rstn = 1'b1;
        repeat (4) @(negedge mclk);
        run(with_sum(40'h28_0000_0000), 48, 1'b0, 1'b0);
        check(cfg === 4'b0101 && bit_ok === 1'b1, "range cfg");
        run(with_sum(40'h68_1234_5678), 48, 1'b0, 1'b0);
        check(cfg === 4'b1101 && bit_ok === 1'b0, "self test on");
        run(with_sum(40'h28_0000_0000) ^ 48'h0000_0000_0001, 48, 1'b1, 1'b0);
        check(cfg === 4'b1101, "corrupt kept");
        sample = {16'h12c0, 16'h0192};
        health_fail = 1'b1;
        run(with_sum(40'h28_0000_0000), 48, 1'b1, 1'b1);
        check(cfg === 4'b0101 && bit_ok === 1'b1, "self test off");
        run(with_sum(40'h68_0000_0000), 40, 1'b0, 1'b0);
        check(cfg === 4'b0101, "short frame ignored");
        run(with_sum(40'h08_0000_0000), 48, 1'b0, 1'b0);
        check(cfg === 4'b0001 && bit_ok === 1'b1, "internal range");
        wrap_up();
    end
endmodule
`default_nettype wire
